// *** logic/sos_pkg.sv ***
package sos_pkg;

	// Register word offsets on the Avalon bus
	localparam logic [4:0] ADDR_FAST_MODE  = 5'h00;
	localparam logic [4:0] ADDR_FAST_FUNC  = 5'h04;
	localparam logic [4:0] ADDR_RELAY1     = 5'h08;
	localparam logic [4:0] ADDR_RELAY2     = 5'h0c;
	localparam logic [4:0] ADDR_OC         = 5'h10;
	localparam logic [4:0] ADDR_OUT_STATE  = 5'h14;

	// Reset values
	localparam logic [7:0] RST_FAST_MODE   = 8'h00;
	localparam logic [7:0] RST_FAST_FUNC   = 8'h00;
	localparam logic [7:0] RST_RELAY1      = 8'h02;
	localparam logic [7:0] RST_RELAY2      = 8'h00;
	localparam logic [7:0] RST_OC          = 8'h01;

	// Fast pin mode field
	localparam int         FAST_MODE_BIT   = 0;
	localparam logic       FAST_MODE_PULSE = 1'b0;
	localparam logic       FAST_MODE_SW    = 1'b1;

	// Terminal indices, also bit positions of the output state word
	localparam int         NUM_TERM        = 5;
	localparam int         T_FAST          = 0;
	localparam int         T_RELAY1        = 1;
	localparam int         T_RELAY2        = 2;
	localparam int         T_OC            = 3;
	localparam int         T_FAST_PIN      = 4;

	// Function codes
	localparam logic [7:0] FN_NONE         = 8'h00;
	localparam logic [7:0] FN_FREQ_REACHED = 8'h01;
	localparam logic [7:0] FN_FREQ_LEVEL   = 8'h02;
	localparam logic [7:0] FN_FAULT_STOP   = 8'h03;
	localparam logic [7:0] FN_MOTOR_OVL    = 8'h04;
	localparam logic [7:0] FN_DRIVE_OVL    = 8'h05;
	localparam logic [7:0] FN_ZERO_RUN     = 8'h06;
	localparam logic [7:0] FN_ZERO_ANY     = 8'h07;
	localparam logic [7:0] FN_UPPER_LIM    = 8'h08;
	localparam logic [7:0] FN_LOWER_LIM    = 8'h09;
	localparam logic [7:0] FN_COUNT_SET    = 8'h0a;
	localparam logic [7:0] FN_COUNT_DESIG  = 8'h0b;
	localparam logic [7:0] FN_LENGTH       = 8'h0c;
	localparam logic [7:0] FN_SEQ_CYCLE    = 8'h0d;
	localparam logic [7:0] FN_RUN_TIME     = 8'h0e;
	localparam logic [7:0] FN_FREQ_LIMITED = 8'h0f;
	localparam logic [7:0] FN_TORQUE_LIM   = 8'h10;
	localparam logic [7:0] FN_READY        = 8'h11;
	localparam logic [7:0] FN_RUNNING      = 8'h12;
	localparam logic [7:0] FN_AI_GREATER   = 8'h13;
	localparam logic [7:0] FN_UNDERVOLT    = 8'h14;

	// Timing and analog input width
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned SEQ_PULSE_MS    = 250;
	localparam int unsigned SEQ_PULSE_CYC   = SEQ_PULSE_MS * (CLK_HZ / 1000);
	localparam int unsigned OVL_LEAD_S      = 10;
	localparam int unsigned OVL_LEAD_CYC    = OVL_LEAD_S * CLK_HZ;
	localparam int          AI_W            = 12;

	// Drive status conditions from the surrounding blocks
	typedef struct packed {
		logic            freq_reached;
		logic            frequency_level_detect_one;
		logic            fault_stop;
		logic            motor_ovl_warn;
		logic            drive_ovl_pending;
		logic [31:0]     drive_ovl_eta;
		logic            running;
		logic            freq_zero;
		logic            at_upper_limit;
		logic            at_lower_limit;
		logic            count_set_hit;
		logic            count_desig_hit;
		logic            length_over;
		logic            seq_cycle_done;
		logic            run_time_over;
		logic            set_above_upper;
		logic            set_below_lower;
		logic            speed_mode;
		logic            torque_at_limit;
		logic            main_stable;
		logic            ctrl_stable;
		logic            fault_any;
		logic [AI_W-1:0] analog_input_one;
		logic [AI_W-1:0] analog_input_two;
		logic            undervoltage;
	} sos_status_type;

endpackage : sos_pkg

// *** logic/sos_selector.sv ***
`timescale 1ns/1ps
module sos_selector #(
	parameter int unsigned SEQ_PULSE_CYC = sos_pkg::SEQ_PULSE_CYC,
	parameter int unsigned OVL_LEAD_CYC  = sos_pkg::OVL_LEAD_CYC
) (
	input  wire logic                clk_sys,
	input  wire logic                arst_n,
	input  wire logic [4:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	output logic [31:0]              readdata,
	output logic                     waitrequest,
	input  wire sos_pkg::sos_status_type status,
	input  wire logic                pulse_train_in,
	output logic                     fast_output_pin,
	output logic                     relay_one,
	output logic                     relay_two,
	output logic                     open_collector_output
);
	import sos_pkg::*;

	// Pulse timer is 24 bits wide; longer pulses need a wider counter
	if (SEQ_PULSE_CYC < 1 || SEQ_PULSE_CYC > 32'h00ffffff) begin : g_bad_pulse
		$error("SEQ_PULSE_CYC out of range");
	end
	if (OVL_LEAD_CYC < 1) begin : g_bad_lead
		$error("OVL_LEAD_CYC out of range");
	end

	typedef struct packed {
		logic                      fast_mode;
		logic [NUM_TERM-2:0][7:0]  func;
		logic                      ack;
		logic [31:0]               rdata;
		logic [23:0]               seq_cnt;
		logic [NUM_TERM-1:0]       out;
	} sos_state_type;

	sos_state_type state_q;
	sos_state_type state_d;

	logic                seq_pulse;
	logic                drive_ovl_warn;
	logic                ai_greater;
	logic                ready_run;
	logic                freq_limited;
	logic [NUM_TERM-2:0] term_on;

	// Derived conditions shared by all terminals
	assign seq_pulse      = (state_q.seq_cnt != 24'h000000);
	assign drive_ovl_warn = status.drive_ovl_pending
		&& (status.drive_ovl_eta <= OVL_LEAD_CYC);
	assign ai_greater     = status.analog_input_one > status.analog_input_two;
	assign ready_run      = status.main_stable && status.ctrl_stable
		&& !status.fault_any;
	assign freq_limited   = (status.set_above_upper && status.at_upper_limit)
		|| (status.set_below_lower && status.at_lower_limit);

	// One selector per terminal, all reading the same conditions
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TERM - 1; gi++) begin : g_term
			always_comb begin
				case (state_q.func[gi])
					FN_NONE:         term_on[gi] = 1'b0;
					FN_FREQ_REACHED: term_on[gi] = status.freq_reached;
					FN_FREQ_LEVEL:   term_on[gi] = status.frequency_level_detect_one;
					FN_FAULT_STOP:   term_on[gi] = status.fault_stop;
					FN_MOTOR_OVL:    term_on[gi] = status.motor_ovl_warn;
					FN_DRIVE_OVL:    term_on[gi] = drive_ovl_warn;
					FN_ZERO_RUN:     term_on[gi] = status.running
						&& status.freq_zero;
					FN_ZERO_ANY:     term_on[gi] = status.freq_zero
						|| !status.running;
					FN_UPPER_LIM:    term_on[gi] = status.at_upper_limit;
					FN_LOWER_LIM:    term_on[gi] = status.at_lower_limit
						&& status.running;
					FN_COUNT_SET:    term_on[gi] = status.count_set_hit;
					FN_COUNT_DESIG:  term_on[gi] = status.count_desig_hit;
					FN_LENGTH:       term_on[gi] = status.length_over;
					FN_SEQ_CYCLE:    term_on[gi] = seq_pulse;
					FN_RUN_TIME:     term_on[gi] = status.run_time_over;
					FN_FREQ_LIMITED: term_on[gi] = freq_limited;
					FN_TORQUE_LIM:   term_on[gi] = status.speed_mode
						&& status.torque_at_limit;
					FN_READY:        term_on[gi] = ready_run;
					FN_RUNNING:      term_on[gi] = status.running;
					FN_AI_GREATER:   term_on[gi] = ai_greater;
					FN_UNDERVOLT:    term_on[gi] = status.undervoltage;
					default:         term_on[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Next state: bus slave, sequence pulse timer, output flops
	always_comb begin
		state_d = state_q;

		// One wait cycle per access; read data is captured in that cycle
		state_d.ack = (read || write) && !state_q.ack;
		if ((read || write) && !state_q.ack) begin
			case (address)
				ADDR_FAST_MODE: state_d.rdata = {31'h0, state_q.fast_mode};
				ADDR_FAST_FUNC: state_d.rdata = {24'h0, state_q.func[T_FAST]};
				ADDR_RELAY1:    state_d.rdata = {24'h0, state_q.func[T_RELAY1]};
				ADDR_RELAY2:    state_d.rdata = {24'h0, state_q.func[T_RELAY2]};
				ADDR_OC:        state_d.rdata = {24'h0, state_q.func[T_OC]};
				ADDR_OUT_STATE: state_d.rdata = {27'h0, state_q.out};
				default:        state_d.rdata = 32'h00000000;
			endcase
		end
		// Writes land on the edge where waitrequest is low
		if (write && state_q.ack) begin
			case (address)
				ADDR_FAST_MODE: state_d.fast_mode = writedata[FAST_MODE_BIT];
				ADDR_FAST_FUNC: state_d.func[T_FAST] = writedata[7:0];
				ADDR_RELAY1:    state_d.func[T_RELAY1] = writedata[7:0];
				ADDR_RELAY2:    state_d.func[T_RELAY2] = writedata[7:0];
				ADDR_OC:        state_d.func[T_OC] = writedata[7:0];
				default:        state_d.fast_mode = state_q.fast_mode;
			endcase
		end

		// A new cycle-done event restarts the pulse rather than being lost
		if (status.seq_cycle_done)
			state_d.seq_cnt = SEQ_PULSE_CYC[23:0];
		else if (state_q.seq_cnt != 24'h000000)
			state_d.seq_cnt = state_q.seq_cnt - 24'h000001;

		state_d.out[T_FAST]   = term_on[T_FAST];
		state_d.out[T_RELAY1] = term_on[T_RELAY1];
		state_d.out[T_RELAY2] = term_on[T_RELAY2];
		state_d.out[T_OC]     = term_on[T_OC];
		// Switch selector is ignored while the pin carries the pulse train
		state_d.out[T_FAST_PIN] = (state_q.fast_mode == FAST_MODE_SW)
			? term_on[T_FAST] : pulse_train_in;
	end

	// State register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q.fast_mode        <= RST_FAST_MODE[FAST_MODE_BIT];
			state_q.func[T_FAST]     <= RST_FAST_FUNC;
			state_q.func[T_RELAY1]   <= RST_RELAY1;
			state_q.func[T_RELAY2]   <= RST_RELAY2;
			state_q.func[T_OC]       <= RST_OC;
			state_q.ack              <= 1'b0;
			state_q.rdata            <= 32'h00000000;
			state_q.seq_cnt          <= 24'h000000;
			state_q.out              <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Port drive
	assign waitrequest           = (read || write) && !state_q.ack;
	assign readdata              = state_q.rdata;
	assign fast_output_pin       = state_q.out[T_FAST_PIN];
	assign relay_one             = state_q.out[T_RELAY1];
	assign relay_two             = state_q.out[T_RELAY2];
	assign open_collector_output = state_q.out[T_OC];

endmodule : sos_selector

// *** tb/sos_load_model.sv ***
`timescale 1ns/1ps
module sos_load_model (
	input  wire logic       fast_output_pin,
	input  wire logic       relay_one,
	input  wire logic       relay_two,
	input  wire logic       open_collector_output,
	output logic      [3:0] seen
);
	// Coils and lamps follow the terminals; contact bounce not modelled
	assign seen = {fast_output_pin, relay_one, relay_two, open_collector_output};
endmodule : sos_load_model

// *** tb/sos_selector_props.sv ***
`timescale 1ns/1ps
module sos_selector_props #(
	parameter int unsigned SEQ_PULSE_CYC = 8,
	parameter int unsigned OVL_LEAD_CYC  = 100
) (
	input  wire logic                    clk_sys,
	input  wire logic                    arst_n,
	input  wire logic [4:0]              address,
	input  wire logic                    write,
	input  wire logic [31:0]             writedata,
	input  wire logic                    waitrequest,
	input  wire sos_pkg::sos_status_type status,
	input  wire logic                    pulse_train_in,
	input  wire logic                    fast_output_pin,
	input  wire logic                    relay_one
);
	import sos_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic [7:0] r1_q;
	logic       md_q;
	// Shadow of relay one code and fast pin mode, taken when a write completes
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			r1_q <= RST_RELAY1;
			md_q <= RST_FAST_MODE[0];
		end else if (write && !waitrequest) begin
			if (address == ADDR_RELAY1) r1_q <= writedata[7:0];
			if (address == ADDR_FAST_MODE) md_q <= writedata[0];
		end
	end
	// Code seen one edge back, outside reset
	sequence s_code(logic [7:0] c);
		$past(arst_n) && $past(r1_q) == c;
	endsequence
	// Only an 8-cycle pulse can be matched by the literal repetition below
	sequence s_evt;
		SEQ_PULSE_CYC == 8 && r1_q == FN_SEQ_CYCLE && status.seq_cycle_done;
	endsequence
	// Pulse length fixed at 8 because repetition counts must be literal
	sequence s_pulse;
		relay_one[*8] ##1 !relay_one;
	endsequence
	AST_R1_NONE: assert property (s_code(FN_NONE) |-> !relay_one)
		else $error("code zero drove relay one");
	AST_R1_FAULT: assert property (s_code(FN_FAULT_STOP) |->
		relay_one == $past(status.fault_stop))
		else $error("fault stop mismatch");
	AST_R1_DOVL: assert property (s_code(FN_DRIVE_OVL) |->
		relay_one == $past(status.drive_ovl_pending && status.drive_ovl_eta <= OVL_LEAD_CYC))
		else $error("drive overload warning mismatch");
	AST_R1_ZRUN: assert property (s_code(FN_ZERO_RUN) |->
		relay_one == $past(status.running && status.freq_zero))
		else $error("zero run mismatch");
	AST_R1_ZANY: assert property (s_code(FN_ZERO_ANY) |->
		relay_one == $past(status.freq_zero || !status.running))
		else $error("zero any mismatch");
	AST_R1_READY: assert property (s_code(FN_READY) |-> relay_one ==
		$past(status.main_stable && status.ctrl_stable && !status.fault_any))
		else $error("ready mismatch");
	AST_R1_AI: assert property (s_code(FN_AI_GREATER) |-> relay_one ==
		$past(status.analog_input_one > status.analog_input_two))
		else $error("analog compare mismatch");
	AST_R1_RSV: assert property ($past(arst_n) && $past(r1_q) > FN_UNDERVOLT |->
		!relay_one)
		else $error("reserved code drove relay one");
	AST_FAST_PULSE: assert property ($past(arst_n) && !$past(md_q) |->
		fast_output_pin == $past(pulse_train_in))
		else $error("pulse mode not followed");
	// Timer then output flop: pulse shows two edges after the event
	AST_SEQ_PULSE: assert property (s_evt |=> ##1 s_pulse)
		else $error("cycle pulse length wrong");
endmodule : sos_selector_props
bind sos_selector sos_selector_props #(
	.SEQ_PULSE_CYC(SEQ_PULSE_CYC),
	.OVL_LEAD_CYC (OVL_LEAD_CYC)
) sos_selector_props_inst (
	.clk_sys        (clk_sys),
	.arst_n         (arst_n),
	.address        (address),
	.write          (write),
	.writedata      (writedata),
	.waitrequest    (waitrequest),
	.status         (status),
	.pulse_train_in (pulse_train_in),
	.fast_output_pin(fast_output_pin),
	.relay_one      (relay_one)
);

// *** tb/sos_selector_test.sv ***
`timescale 1ns/1ps
module sos_selector_test;
	import sos_pkg::*;
	logic           clk_sys, arst_n, read, write, waitrequest, pulse_train_in;
	logic           fast_output_pin, relay_one, relay_two, open_collector_output, e;
	logic [4:0]     address;
	logic [31:0]    writedata, readdata, got;
	logic [3:0]     seen;
	sos_status_type status;
	sos_status_type pats[4];
	int             miscompares, check_count, cyc;
	logic [22:0]    ex[4] = '{23'h15dfde, 23'h000080, 23'h0e0220, 23'h000180};
	logic [7:0]     rv[5] = '{RST_FAST_MODE, RST_FAST_FUNC, RST_RELAY1, RST_RELAY2, RST_OC};
	sos_selector #(.SEQ_PULSE_CYC(8), .OVL_LEAD_CYC(100)) sos_selector_inst (
		.clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .status(status), .pulse_train_in(pulse_train_in),
		.fast_output_pin(fast_output_pin), .relay_one(relay_one), .relay_two(relay_two),
		.open_collector_output(open_collector_output));
	sos_load_model sos_load_model_inst (.fast_output_pin(fast_output_pin),
		.relay_one(relay_one), .relay_two(relay_two),
		.open_collector_output(open_collector_output), .seen(seen));
	// Free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Hang guard; whole run needs about 1400 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// Request held until waitrequest is sampled low
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		address   <= a;
		writedata <= d;
		write     <= 1'b1;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		address <= a;
		read    <= 1'b1;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask : rd
	initial begin
		arst_n = 1'b0;
		address = 5'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		status = '0;
		pulse_train_in = 1'b0;
		pats[0] = '1;
		pats[0].seq_cycle_done = 1'b0;
		pats[1] = '0;
		pats[2] = '{drive_ovl_pending: 1'b1, drive_ovl_eta: 32'h64, running: 1'b1,
			at_lower_limit: 1'b1, set_above_upper: 1'b1, torque_at_limit: 1'b1,
			main_stable: 1'b1, ctrl_stable: 1'b1, analog_input_one: 12'h005,
			analog_input_two: 12'h003, default: '0};
		// Stopped at zero frequency with limit flags up: stop gating must bite
		pats[3] = '{freq_zero: 1'b1, at_upper_limit: 1'b1, at_lower_limit: 1'b1, default: '0};
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		// Reset values, unused upper bits, unmapped hole
		for (int k = 0; k < 5; k++) begin
			rd(5'(4 * k), got);
			chk(got, {24'h0, rv[k]});
		end
		wr(ADDR_RELAY2, 32'hffff_ff13);
		rd(ADDR_RELAY2, got);
		chk(got, 32'h13);
		rd(5'h18, got);
		chk(got, 32'h0);
		$display("test registers done");
		// Every code on all four terminals under four status patterns
		wr(ADDR_FAST_MODE, 32'h1);
		for (int p = 0; p < 4; p++) begin
			for (int c = 0; c < 23; c++) begin
				for (int k = 0; k < 4; k++) wr(5'(4 * k + 4), 32'(c));
				status <= pats[p];
				e = ex[p][c];
				repeat (2) @(posedge clk_sys);
				chk(32'(seen[1:0]), {30'h0, e, e});
				chk(32'(seen[3:2]), {30'h0, e, e});
			end
		end
		$display("test codes done");
		// Different codes at once, then pulse mode on the fast pin
		status <= '0;
		wr(ADDR_FAST_FUNC, 32'(FN_ZERO_ANY));
		wr(ADDR_RELAY1, 32'(FN_FAULT_STOP));
		wr(ADDR_RELAY2, 32'(FN_ZERO_ANY));
		wr(ADDR_OC, 32'(FN_READY));
		repeat (2) @(posedge clk_sys);
		chk(32'(seen), 32'h0a);
		rd(ADDR_OUT_STATE, got);
		chk(got, 32'h15);
		wr(ADDR_FAST_MODE, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk(32'(fast_output_pin), 32'h0);
		pulse_train_in <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(32'(fast_output_pin), 32'h1);
		$display("test terminals done");
		// One cycle-complete event gives one pulse of the set length
		wr(ADDR_RELAY1, 32'(FN_SEQ_CYCLE));
		status.seq_cycle_done <= 1'b1;
		@(posedge clk_sys);
		status.seq_cycle_done <= 1'b0;
		got = 32'h0;
		repeat (20) begin
			@(posedge clk_sys);
			got += 32'(relay_one);
		end
		chk(got, 32'h8);
		$display("test pulse done");
		stop_test();
	end
endmodule : sos_selector_test
